//--- verification/pin_model.sv
// board side of the port 6/7 pins: pull-ups and optional outside drive
`timescale 1ns/1ns
module pin_model (
    input wire logic clk_sys_i,
    input wire logic [7:0] p7_o_i,
    input wire logic [7:0] p7_oe_i,
    input wire logic [3:0] p7_pu_i,
    input wire logic [4:0] p6_o_i,
    input wire logic [4:0] p6_oe_i,
    input wire logic [3:0] p6_pu_i,
    input wire logic [12:0] ext_en_i,
    input wire logic [12:0] ext_val_i,
    output logic [12:0] pin_o
);
    logic flip_q = 1'b0;
    logic [12:0] oe, dv, pu;
    assign oe = {p6_oe_i, p7_oe_i};
    assign dv = {p6_o_i, p7_o_i};
    assign pu = {1'b0, p6_pu_i, 4'h0, p7_pu_i};
    always @(posedge clk_sys_i) flip_q <= ~flip_q;
    // a floating pin wanders so a stale level never passes for a driven one
    always_comb begin
        for (int i = 0; i < 13; i++) begin
            pin_o[i] = oe[i] ? dv[i] : ext_en_i[i] ? ext_val_i[i] :
                pu[i] | (flip_q ^ i[0]);
        end
    end
endmodule // pin_model

//--- verification/port67_checker.sv
// assertions on the port 6/7 pin-select block, bound to its top
`timescale 1ns/1ns
`include "port67_defs.svh"
module port67_checker
    import port67_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [15:0] adr_i,
    input wire logic [7:0] dat_o,
    input wire logic ack_o,
    input wire logic hw_standby_i,
    input wire logic sw_standby_i,
    input wire periph_ctl_t periph_i,
    input wire logic [4:0] p6_pin_o,
    input wire logic [4:0] p6_pin_oe_o,
    input wire logic [7:0] p7_pin_oe_o,
    input wire logic [3:0] p7_pullup_o,
    input wire logic timer_capture_input_o,
    input wire logic vsync_input_o,
    input wire logic [3:0] keysense_input_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    ack_time_a: assert property ($rose(cyc_i && stb_i) |=> ack_o)
        else $error("ack not one cycle after request");
    dir_read_a: assert property (ack_o &&
        $past(cyc_i && !we_i && adr_i == `P7_DIR_OFFSET) |-> dat_o == 8'hff)
        else $error("direction read not all ones");
    sync_pin_a: assert property (periph_i.sync_output_enable |->
        p6_pin_oe_o[2] && p6_pin_o[2] == periph_i.vsync_output)
        else $error("pin 2 not carrying sync output");
    tmrb_pin_a: assert property (!periph_i.sync_output_enable &&
        periph_i.timer_outb_enable |->
        p6_pin_oe_o[2] && p6_pin_o[2] == periph_i.timer_out_b)
        else $error("pin 2 not carrying timer b");
    tmra_pin_a: assert property (periph_i.timer_outa_enable |->
        p6_pin_oe_o[1] && p6_pin_o[1] == periph_i.timer_out_a)
        else $error("pin 1 not carrying timer a");
    pullup_dir_a: assert property (
        (p7_pullup_o & p7_pin_oe_o[3:0]) == 4'h0)
        else $error("pull-up on an output pin");
    shared_in_a: assert property (
        timer_capture_input_o == vsync_input_o &&
        vsync_input_o == keysense_input_o[3])
        else $error("pin 3 consumers disagree");
    rst_clear_a: assert property ($fell(srst_i) |-> !ack_o &&
        p7_pin_oe_o[3:0] == 4'h0 && p7_pullup_o == 4'h0)
        else $error("outputs not cleared by reset");
    hw_clear_a: assert property (hw_standby_i |=>
        p7_pin_oe_o[3:0] == 4'h0 && p7_pullup_o == 4'h0)
        else $error("outputs not cleared in hardware standby");
    sw_hold_a: assert property (sw_standby_i && !hw_standby_i |=>
        $stable(p7_pin_oe_o[3:0]))
        else $error("direction changed in software standby");
    cover property (periph_i.sync_output_enable && p6_pin_oe_o[2]);
    cover property (sw_standby_i && cyc_i && we_i);
    cover property (ack_o && dat_o == 8'hff);
endmodule // port67_checker
bind port67_gpio port67_checker i_chk (.*);

//--- verification/testbench.sv
// self-checking bench for the port 6/7 pin-select block
`timescale 1ns/1ns
`include "port67_defs.svh"
module testbench
    import port67_pkg::*;
;
    logic clk_sys_i = 1'b0, srst_i = 1'b1, lv0, lv1;
    logic hw_standby_i = 1'b0, sw_standby_i = 1'b0, p7_upper_mode_i = 1'b0;
    logic [7:0] keysense_mask_bits_i = 8'hf0, rd;
    logic [3:0] p7_upper_out_i = 4'h0, p7_upper_oe_i = 4'h0;
    periph_ctl_t periph_i = '0;
    wb_req_t req = '0;
    logic [12:0] ext_en = 13'h0000, ext_val = 13'h0000;
    wire logic cyc_i, stb_i, we_i, sel_i;
    wire logic [15:0] adr_i;
    wire logic [7:0] dat_i;
    logic [7:0] dat_o, p7_pin_o, p7_pin_oe_o, p7_pin_sync_o;
    logic ack_o, external_interrupt_0_o, timer_capture_input_o;
    logic vsync_input_o, timer_ext_clock_input_o;
    logic [4:0] p6_pin_o, p6_pin_oe_o;
    logic [3:0] p6_pullup_o, p7_pullup_o, keysense_input_o;
    wire logic [4:0] p6_pin_i;
    wire logic [7:0] p7_pin_i;
    int fails = 0, comparisons = 0;
    assign {cyc_i, stb_i, we_i, sel_i, adr_i, dat_i} = req;
    always #50 clk_sys_i = ~clk_sys_i;
    port67_gpio i_dut (.*);
    pin_model i_pins (.clk_sys_i(clk_sys_i), .p7_o_i(p7_pin_o),
        .p7_oe_i(p7_pin_oe_o), .p7_pu_i(p7_pullup_o), .p6_o_i(p6_pin_o),
        .p6_oe_i(p6_pin_oe_o), .p6_pu_i(p6_pullup_o), .ext_en_i(ext_en),
        .ext_val_i(ext_val), .pin_o({p6_pin_i, p7_pin_i}));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            $display("unexpected at %0t: seen %h expected %h",
                $time, seen, exp);
            fails++;
        end
    endtask
    task automatic bus(input logic w, input logic [15:0] a,
            input logic [7:0] d);
        @(posedge clk_sys_i);
        req <= '{1'b1, 1'b1, w, 1'b1, a, d};
        do @(posedge clk_sys_i); while (ack_o !== 1'b1);
        rd = dat_o;
        req <= '0;
    endtask
    task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk(rd, exp);
    endtask
    // pins pass a three-flop synchroniser plus an agreement stage
    task automatic settle;
        repeat (6) @(posedge clk_sys_i);
    endtask
    task automatic test_done;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        fails++;
        test_done;
    end
    initial begin
        repeat (4) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        rdc(`P7_LATCH_OFFSET, 8'h00);
        rdc(`KEY_PULLUP_OFFSET, 8'h00);
        rdc(`P7_DIR_OFFSET, 8'hff);
        rdc(16'h0000, 8'h00);
        bus(1'b1, `P7_DIR_OFFSET, 8'h0f);
        bus(1'b1, `P7_LATCH_OFFSET, 8'ha5);
        ext_en <= 13'h00f0;
        ext_val <= 13'h0030;
        settle;
        chk({p7_pin_oe_o[3:0], p7_pin_o[3:0]}, 8'hf5);
        rdc(`P7_LATCH_OFFSET, 8'h35);
        bus(1'b1, `KEY_PULLUP_OFFSET, 8'hff);
        bus(1'b1, `P7_DIR_OFFSET, 8'h05);
        settle;
        chk({p6_pullup_o, p7_pullup_o}, 8'hfa);
        rdc(`KEY_PULLUP_OFFSET, 8'hff);
        sw_standby_i <= 1'b1;
        bus(1'b1, `P7_DIR_OFFSET, 8'h00);
        bus(1'b1, `P7_LATCH_OFFSET, 8'h00);
        settle;
        rdc(`P7_LATCH_OFFSET, 8'h3f);
        chk(p7_pin_oe_o, 8'h05);
        sw_standby_i <= 1'b0;
        hw_standby_i <= 1'b1;
        settle;
        hw_standby_i <= 1'b0;
        chk(p7_pin_oe_o, 8'h00);
        rdc(`KEY_PULLUP_OFFSET, 8'h00);
        bus(1'b1, `P7_DIR_OFFSET, 8'hff);
        rdc(`P7_LATCH_OFFSET, 8'h00);
        bus(1'b1, `P7_DIR_OFFSET, 8'h00);
        ext_en <= 13'h1fff;
        // port 7 pin 3 low, so bit 7 tells the empty bit from the pin
        ext_val <= 13'h1604;
        settle;
        rdc(`P6_READ_OFFSET, 8'h96);
        keysense_mask_bits_i <= 8'h00;
        settle;
        rdc(`P6_READ_OFFSET, 8'h46);
        chk(p7_pin_sync_o, 8'h04);
        for (int i = 0; i < 8; i++) begin
            periph_i <= '{1'b0, i[1], i[2], i[0], 1'b0, 1'b0, 1'b1,
                1'b0, 1'b1};
            @(negedge clk_sys_i);
            chk({6'h00, p6_pin_oe_o[2:1]}, {6'h00, i[1] | i[0], i[2]});
            chk({6'h00, p6_pin_o[2:1] & p6_pin_oe_o[2:1]},
                {6'h00, i[1], i[2]});
            @(posedge clk_sys_i);
        end
        for (int e = 1; e >= 0; e--) begin
            for (int v = 0; v < 2; v++) begin
                // select-lo alone must not pick the external clock
                periph_i <= '{e[0], 1'b0, 1'b0, 1'b0, e[0], 1'b1, 1'b0,
                    1'b0, 1'b0};
                ext_val[12:8] <= {5{v[0]}} & 5'b11001;
                settle;
                if (v == 0) begin
                    lv0 = external_interrupt_0_o;
                    lv1 = timer_ext_clock_input_o;
                end
                chk({2'b00, external_interrupt_0_o,
                    timer_capture_input_o, vsync_input_o,
                    keysense_input_o[3], keysense_input_o[0],
                    timer_ext_clock_input_o},
                    {2'b00, e[0] ? v[0] : lv0, {4{v[0]}}, e[0] ? v[0] : lv1});
            end
        end
        p7_upper_mode_i <= 1'b1;
        p7_upper_oe_i <= 4'hf;
        p7_upper_out_i <= 4'h9;
        @(negedge clk_sys_i);
        chk({p7_pin_oe_o[7:4], p7_pin_o[7:4]}, 8'hf9);
        bus(1'b1, `KEY_PULLUP_OFFSET, 8'h3c);
        srst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        rdc(`KEY_PULLUP_OFFSET, 8'h00);
        test_done;
    end
endmodule // testbench

//--- verilog/pin_sync3.sv
// three-flop pin synchroniser, one generate lane per bit
`timescale 1ns/1ns
module pin_sync3 #(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] hold_q;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_lane
            // a change counts only once the second and third stages agree
            always_ff @(posedge clk_sys_i) begin
                if (srst_i) begin
                    s1_q[g] <= 1'b0;
                    s2_q[g] <= 1'b0;
                    s3_q[g] <= 1'b0;
                    hold_q[g] <= 1'b0;
                end else begin
                    s1_q[g] <= async_i[g];
                    s2_q[g] <= s1_q[g];
                    s3_q[g] <= s2_q[g];
                    if (s2_q[g] == s3_q[g]) begin
                        hold_q[g] <= s3_q[g];
                    end
                end
            end
        end
    endgenerate

    assign sync_o = hold_q;
endmodule // pin_sync3

//--- verilog/port67_defs.svh
// port 6/7 register offsets, reset values and fixed read values
`ifndef PORT67_DEFS_SVH
`define PORT67_DEFS_SVH
`define P7_DIR_OFFSET 16'hffbc
`define P7_LATCH_OFFSET 16'hffbe
`define KEY_PULLUP_OFFSET 16'hfff2
`define P6_DIR_OFFSET 16'hffb9
`define P6_READ_OFFSET 16'hffbb
`define P7_DIR_RESET 8'h00
`define P7_LATCH_RESET 8'h00
`define KEY_PULLUP_RESET 8'h00
`define P6_DIR_RESET 8'h80
`define DIR_READ_VALUE 8'hff
`define UNMAPPED_READ 8'h00
`define EMPTY_BIT_VALUE 1'b1
`endif

//--- verilog/port67_gpio.sv
// port 6 (bits 4..0) and port 7 pin select, latches and wishbone slave
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ns
`include "port67_defs.svh"
module port67_gpio
    import port67_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // classic wishbone slave, 8-bit data
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic sel_i,
    input wire logic [15:0] adr_i,
    input wire logic [7:0] dat_i,
    output logic [7:0] dat_o,
    output logic ack_o,
    // standby modes
    input wire logic hw_standby_i,
    input wire logic sw_standby_i,
    // chip operating mode: 1 selects the bus/host use of port 7 pins 7..4
    input wire logic p7_upper_mode_i,
    input wire logic [3:0] p7_upper_out_i,
    input wire logic [3:0] p7_upper_oe_i,
    // on-chip peripheral controls and outputs
    input wire periph_ctl_t periph_i,
    input wire logic [7:0] keysense_mask_bits_i,
    // port 6 pins 4..0
    input wire logic [4:0] p6_pin_i,
    output logic [4:0] p6_pin_o,
    output logic [4:0] p6_pin_oe_o,
    output logic [3:0] p6_pullup_o,
    // port 7 pins
    input wire logic [7:0] p7_pin_i,
    output logic [7:0] p7_pin_o,
    output logic [7:0] p7_pin_oe_o,
    output logic [3:0] p7_pullup_o,
    // peripheral inputs taken from the pins
    output logic external_interrupt_0_o,
    output logic timer_capture_input_o,
    output logic vsync_input_o,
    output logic timer_ext_clock_input_o,
    output logic [3:0] keysense_input_o,
    output logic [7:0] p7_pin_sync_o
);
    ////////////////////////////////////////////////////////////////////////
    // registers
    bus_state_t state_q;
    bus_state_t state_d;
    logic [7:0] port7_direction_q;
    logic [7:0] port7_output_latch_q;
    logic [7:0] keysense_pullup_enable_q;
    logic [7:0] port6_direction_q;
    logic [7:0] port6_data_q;
    logic [7:0] rdata_q;
    logic [4:0] p6_sync;
    logic [7:0] p7_sync;
    wb_req_t req;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    pin_sync3 #(.WIDTH(5)) u_sync6 (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .async_i(p6_pin_i),
        .sync_o(p6_sync)
    );
    pin_sync3 #(.WIDTH(8)) u_sync7 (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .async_i(p7_pin_i),
        .sync_o(p7_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, sel: sel_i,
                   adr: adr_i, dat: dat_i};
    wire req_new = req.cyc && req.stb && (state_q == ST_IDLE);
    wire wr_go = req_new && req.we && req.sel;
    wire hit_p7_dir = (req.adr == `P7_DIR_OFFSET);
    wire hit_p7_latch = (req.adr == `P7_LATCH_OFFSET);
    wire hit_pullup = (req.adr == `KEY_PULLUP_OFFSET);
    wire hit_p6_dir = (req.adr == `P6_DIR_OFFSET);
    wire hit_p6_read = (req.adr == `P6_READ_OFFSET);
    // hardware standby acts like reset; software standby merely holds
    wire clear_all = srst_i || hw_standby_i;
    wire wr_en = wr_go && !sw_standby_i;

    // one wait-free answer: ack the cycle after the request is seen
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (req.cyc && req.stb) begin
                    state_d = ST_ACK;
                end
            end
            ST_ACK: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end
    assign ack_o = (state_q == ST_ACK);

    ////////////////////////////////////////////////////////////////////////
    // direction, latch and pull-up registers
    always_ff @(posedge clk_sys_i) begin
        if (clear_all) begin
            port7_direction_q <= `P7_DIR_RESET;
        end else if (wr_en && hit_p7_dir) begin
            port7_direction_q <= req.dat;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (clear_all) begin
            port7_output_latch_q <= `P7_LATCH_RESET;
        end else if (wr_en && hit_p7_latch) begin
            port7_output_latch_q <= req.dat;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (clear_all) begin
            keysense_pullup_enable_q <= `KEY_PULLUP_RESET;
        end else if (wr_en && hit_pullup) begin
            keysense_pullup_enable_q <= req.dat;
        end
    end

    // port 6 direction kept here so that pull-ups and reads can see it;
    // bit 7 is reserved and stays 1
    always_ff @(posedge clk_sys_i) begin
        if (clear_all) begin
            port6_direction_q <= `P6_DIR_RESET;
        end else if (wr_en && hit_p6_dir) begin
            port6_direction_q <= {1'b1, req.dat[6:0]};
        end
    end

    // port 6 output data for bits 4..0, written at the port 6 read address
    always_ff @(posedge clk_sys_i) begin
        if (clear_all) begin
            port6_data_q <= `P6_DIR_RESET;
        end else if (wr_en && hit_p6_read) begin
            port6_data_q <= {1'b1, req.dat[6:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read-back
    logic [7:0] p7_read;
    logic [7:0] p6_read;
    logic [3:0] p6_hi_in;
    genvar b;
    generate
        for (b = 0; b < 8; b++) begin : g_p7_read
            assign p7_read[b] = port7_direction_q[b] ?
                port7_output_latch_q[b] : p7_sync[b];
        end
        for (b = 0; b < 4; b++) begin : g_p6_hi
            // mask 0 borrows port 7 pin b for port 6 bit b+4
            assign p6_hi_in[b] = keysense_mask_bits_i[b+4] ?
                ((b == 3) ? `EMPTY_BIT_VALUE :
                 (b == 0) ? p6_sync[4] : 1'b0) :
                p7_sync[b];
        end
        for (b = 0; b < 8; b++) begin : g_p6_read
            if (b == 7) begin : g_empty
                // bit 7 has no direction flop behind it: the mask alone
                // chooses between the empty bit and port 7 pin 3
                assign p6_read[b] = p6_hi_in[3];
            end else if (b >= 4) begin : g_hi
                assign p6_read[b] = port6_direction_q[b] ?
                    port6_data_q[b] : p6_hi_in[b-4];
            end else begin : g_lo
                assign p6_read[b] = port6_direction_q[b] ?
                    port6_data_q[b] : p6_sync[b];
            end
        end
    endgenerate
    // pins 6 and 5 of port 6 sit outside this block; as inputs they read zero while their mask bits are set, else port 7 pins 2 and 1

    wire [7:0] rd_mux =
        hit_p7_dir ? `DIR_READ_VALUE :
        hit_p7_latch ? p7_read :
        hit_pullup ? keysense_pullup_enable_q :
        hit_p6_dir ? `DIR_READ_VALUE :
        hit_p6_read ? p6_read : `UNMAPPED_READ;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            rdata_q <= 8'h00;
        end else if (req_new && !req.we) begin
            rdata_q <= rd_mux;
        end
    end
    assign dat_o = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // port 6 pin drive
    wire tmr_ext_clk = periph_i.clock_select_hi && periph_i.clock_select_lo;
    wire p6_2_sync = periph_i.sync_output_enable;
    wire p6_2_tmrb = !p6_2_sync && periph_i.timer_outb_enable;

    always_comb begin
        p6_pin_oe_o = port6_direction_q[4:0];
        p6_pin_o = port6_data_q[4:0];
        // bit 2: sync output wins over timer B, both over plain I/O
        if (p6_2_sync) begin
            p6_pin_oe_o[2] = 1'b1;
            p6_pin_o[2] = periph_i.vsync_output;
        end else if (p6_2_tmrb) begin
            p6_pin_oe_o[2] = 1'b1;
            p6_pin_o[2] = periph_i.timer_out_b;
        end
        if (periph_i.timer_outa_enable) begin
            p6_pin_oe_o[1] = 1'b1;
            p6_pin_o[1] = periph_i.timer_out_a;
        end
    end

    // inputs reach peripherals from the pin whatever the direction
    assign external_interrupt_0_o =
        periph_i.ext_external_interrupt_0_enable & p6_sync[4];
    assign timer_capture_input_o = p6_sync[3];
    assign vsync_input_o = p6_sync[3];
    assign timer_ext_clock_input_o = tmr_ext_clk & p6_sync[0];
    assign keysense_input_o = p6_sync[3:0];
    assign p7_pin_sync_o = p7_sync;

    ////////////////////////////////////////////////////////////////////////
    // port 7 pin drive
    always_comb begin
        p7_pin_oe_o = port7_direction_q;
        p7_pin_o = port7_output_latch_q;
        // only the upper four pins change with the operating mode
        if (p7_upper_mode_i) begin
            p7_pin_oe_o[7:4] = p7_upper_oe_i;
            p7_pin_o[7:4] = p7_upper_out_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pull-ups: input direction and control bit both needed
    assign p7_pullup_o = keysense_pullup_enable_q[7:4] &
        ~port7_direction_q[3:0];
    assign p6_pullup_o = keysense_pullup_enable_q[3:0] &
        ~p6_pin_oe_o[3:0];
endmodule // port67_gpio

//--- verilog/port67_pkg.sv
// types shared by the port 6/7 pin-select logic
package port67_pkg;
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic sel;
        logic [15:0] adr;
        logic [7:0] dat;
    } wb_req_t;
    typedef struct packed {
        logic ext_external_interrupt_0_enable;
        logic sync_output_enable;
        logic timer_outa_enable;
        logic timer_outb_enable;
        logic clock_select_hi;
        logic clock_select_lo;
        logic timer_out_a;
        logic timer_out_b;
        logic vsync_output;
    } periph_ctl_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACK = 2'b01
    } bus_state_t;
endpackage
